// ### logic/sarcs_pkg.sv
package sarcs_pkg;
  localparam int unsigned RESULT_BITS      = 16;
  localparam int unsigned CHAIN_DELAY      = 16;
  localparam int unsigned CLK_SYS_MHZ      = 100;
  localparam int unsigned FAST_RATE_KSPS   = 2500;
  localparam int unsigned SLOW_RATE_KSPS   = 2000;
  localparam int unsigned FAST_PERIOD_CYC  = (CLK_SYS_MHZ * 1000) / FAST_RATE_KSPS;
  localparam int unsigned SLOW_PERIOD_CYC  = (CLK_SYS_MHZ * 1000) / SLOW_RATE_KSPS;
  localparam int unsigned CONV_CYC         = 30;
  localparam logic [1:0]  SYNC_RESET       = 2'h0;
  typedef enum logic [1:0] {
    SARCS_IDLE = 2'b00,
    SARCS_CONV = 2'b01,
    SARCS_READ = 2'b10
  } sarcs_state_t;
endpackage

// ### logic/sarcs_sync.sv
module sarcs_sync
  import sarcs_pkg::*;
#(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // Second stage is the only reader of the first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ### logic/sarcs_top.sv
// Overview of operation
// - Selected after conversion: each serial clock shifts one bit, except the first after a busy start bit
// - Convert rising edge starts conversion unless one is running; every rising edge latches mode
// - Chip-select mode: output driven while convert low
// - Serial input low at edge: chain mode
// - Chain: input reaches output 16 clocks later
// - Serial input high at edge: chip-select mode
// - Chip-select: convert low, or input low outside conversion, enables output
// - Chip-select, input or convert low at completion: busy indicator
// - Speed pin high: stay powered, 2.5 MSPS
// - Speed pin low: power down, 2.0 MSPS
// - Powerdown high, bandgap pin low: both off
// - Result shifts out in step with serial clock
// - Powerdown low enables reference and buffer
module sarcs_top
  import sarcs_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   convert_pin,
  input  wire logic                   sck,
  input  wire logic                   sdi,
  input  wire logic                   speed_mode_select,
  input  wire logic                   ref_powerdown,
  input  wire logic                   bandgap_ref_pin,
  input  wire logic [RESULT_BITS-1:0] conv_code,
  output logic                        sdo_out,
  output logic                        sdo_oe_n,
  output logic                        converting,
  output logic                        core_powered,
  output logic                        ref_enable,
  output logic                        ref_buffer_enable,
  output logic                        bandgap_enable,
  output logic                        chain_mode,
  output logic                        rate_too_fast,
  output logic                        first_result_invalid
);
  logic [3:0]             sync_w;
  logic                   cnv_s;
  logic                   sck_s;
  logic                   sdi_s;
  logic                   spd_s;
  logic                   cnv_d_r;
  logic                   sck_d_r;
  logic                   cnv_rise;
  logic                   sck_rise;
  logic                   sck_fall;
  sarcs_state_t           state_r;
  logic [7:0]             conv_cnt_r;
  logic [7:0]             period_cnt_r;
  logic [RESULT_BITS-1:0] shift_r;
  logic                   busy_en_r;
  logic                   turbo_r;
  logic                   fast_seen_r;
  logic                   select_n;
  logic                   conv_done;
  logic                   busy_now;
  logic                   shift_en;

  // Completion decode, shared by load, busy and output logic
  function automatic logic conv_last(input sarcs_state_t st, input logic [7:0] cnt);
    return (st == SARCS_CONV) && (cnt == 8'h00);
  endfunction

  // Speed pin is asynchronous as well, so it shares the synchroniser
  sarcs_sync #(.WIDTH(4)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({convert_pin, sck, sdi, speed_mode_select}),
    .sync_out (sync_w)
  );

  assign cnv_s    = sync_w[3];
  assign sck_s    = sync_w[2];
  assign sdi_s    = sync_w[1];
  assign spd_s    = sync_w[0];
  assign cnv_rise = cnv_s & ~cnv_d_r;
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnv_d_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      cnv_d_r <= cnv_s;
      sck_d_r <= sck_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chain_mode <= 1'b0;
      turbo_r    <= 1'b0;
    end else if (cnv_rise) begin
      chain_mode <= ~sdi_s;
      turbo_r    <= spd_s;
    end
  end

  // Conversion timing from the internal clock, not the serial clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r    <= SARCS_IDLE;
      conv_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        SARCS_IDLE, SARCS_READ: begin
          if (cnv_rise) begin
            state_r    <= SARCS_CONV;
            conv_cnt_r <= 8'(CONV_CYC - 1);
          end
        end
        SARCS_CONV: begin
          if (conv_cnt_r == 8'h00) begin
            state_r <= SARCS_READ;
          end else begin
            conv_cnt_r <= conv_cnt_r - 8'h01;
          end
        end
        default: state_r <= SARCS_IDLE;
      endcase
    end
  end

  assign converting = (state_r == SARCS_CONV);
  assign conv_done  = conv_last(state_r, conv_cnt_r);

  assign busy_now = ~chain_mode & (~sdi_s | ~cnv_s);

  // Start bit takes the first serial clock, so that clock must not shift
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_en_r <= 1'b0;
    end else if (conv_done) begin
      busy_en_r <= busy_now;
    end else if (cnv_rise || (shift_en && sck_rise)) begin
      busy_en_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_r <= '0;
    end else if (conv_done) begin
      shift_r <= conv_code;
    end else if (shift_en && sck_rise && !busy_en_r) begin
      shift_r <= {shift_r[RESULT_BITS-2:0], chain_mode ? sdi_s : 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sdo_out <= 1'b0;
    end else if (conv_done) begin
      // Low start bit marks completion when the busy indicator is on
      sdo_out <= busy_now ? 1'b0 : conv_code[RESULT_BITS-1];
    end else if (shift_en && sck_fall) begin
      sdo_out <= shift_r[RESULT_BITS-1];
    end
  end

  assign select_n = ~sdi_s | ~cnv_s;

  assign shift_en = (state_r == SARCS_READ) && (chain_mode || select_n);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sdo_oe_n <= 1'b1;
    end else if (chain_mode) begin
      sdo_oe_n <= 1'b0;
    end else begin
      sdo_oe_n <= ~(select_n & ~cnv_s) & ~(select_n & ~converting);
    end
  end

  assign core_powered = turbo_r | converting;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      period_cnt_r  <= 8'hFF;
      rate_too_fast <= 1'b0;
    end else if (cnv_rise) begin
      rate_too_fast <= turbo_r ? (period_cnt_r < 8'(FAST_PERIOD_CYC))
                               : (period_cnt_r < 8'(SLOW_PERIOD_CYC));
      period_cnt_r  <= 8'h01;
    end else if (period_cnt_r != 8'hFF) begin
      period_cnt_r <= period_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fast_seen_r          <= 1'b0;
      first_result_invalid <= 1'b0;
    end else if (cnv_rise) begin
      first_result_invalid <= spd_s & ~fast_seen_r;
      fast_seen_r          <= spd_s;
    end
  end

  assign ref_enable        = ~ref_powerdown;
  assign ref_buffer_enable = ~(ref_powerdown & ~bandgap_ref_pin);
  assign bandgap_enable    = ~(ref_powerdown & ~bandgap_ref_pin) & ~ref_powerdown;
endmodule

// ### bench/sarcs_props.sv
module sarcs_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic convert_pin,
  input wire logic sdi,
  input wire logic ref_powerdown,
  input wire logic bandgap_ref_pin,
  input wire logic sdo_oe_n,
  input wire logic converting,
  input wire logic core_powered,
  input wire logic ref_enable,
  input wire logic ref_buffer_enable,
  input wire logic bandgap_enable,
  input wire logic chain_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_REF: assert property (ref_enable == !ref_powerdown)
    else $error("ref enable");
  AST_BG: assert property (ref_powerdown && !bandgap_ref_pin |->
    !ref_buffer_enable && !bandgap_enable) else $error("ref off");
  AST_GO: assert property ($rose(convert_pin) |-> ##[1:5] converting)
    else $error("no start");
  AST_LEN: assert property ($rose(converting) |-> ##29 converting ##1 !converting)
    else $error("conv length");
  AST_HOLD: assert property (converting && $past(converting) |-> $stable(chain_mode))
    else $error("mode moved");
  // Sync lag of the pins is covered by the five-cycle run; a low input still enables outside conversion
  AST_CSOFF: assert property ((!chain_mode && convert_pin && sdi)[*5] |-> sdo_oe_n)
    else $error("cs drive");
  AST_CSON: assert property ((!chain_mode && !convert_pin && !converting)[*5]
    |-> !sdo_oe_n) else $error("cs enable");
  AST_CHAIN: assert property (chain_mode[*3] |-> !sdo_oe_n)
    else $error("chain drive");
  AST_PWR: assert property (converting |-> core_powered)
    else $error("power");
endmodule
bind sarcs_top sarcs_props u_props (.clk_sys(clk_sys), .rst(rst), .convert_pin(convert_pin),
  .ref_powerdown(ref_powerdown), .bandgap_ref_pin(bandgap_ref_pin), .sdo_oe_n(sdo_oe_n),
  .converting(converting), .core_powered(core_powered), .ref_enable(ref_enable),
  .ref_buffer_enable(ref_buffer_enable), .bandgap_enable(bandgap_enable),
  .chain_mode(chain_mode), .sdi(sdi));

// ### bench/sarcs_host.sv
module sarcs_host (
  input  wire logic clk_sys,
  input  wire logic sdo_out,
  output logic      convert_pin,
  output logic      sck,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    convert_pin = 1'h0;
    sck = 1'h0;
    sdi = 1'h1;
  end
  // mode set by sdi at convert rise
  task automatic start(input logic chain, input logic busy);
    @(negedge clk_sys);
    convert_pin = 1'h0;
    sdi = !chain;
    repeat (3) @(negedge clk_sys);
    convert_pin = 1'h1;
    repeat (3) @(negedge clk_sys);
    sdi = !(chain || busy);
    repeat (40) @(negedge clk_sys);
    // chip-select reads low, chain reads high
    convert_pin = chain;
  endtask
  // sck idles low, bit taken before each rise
  task automatic read(input int n, input logic [31:0] din, output logic [31:0] dout);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = din[i];
      repeat (8) @(negedge clk_sys);
      dout[i] = sdo_out;
      sck = 1'h1;
      repeat (8) @(negedge clk_sys);
      sck = 1'h0;
    end
  endtask
endmodule

// ### bench/sar_adc_convert_serial_port_test.sv
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module sar_adc_convert_serial_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'h0, rst = 1'h1, speed_mode_select = 1'h0;
  logic ref_powerdown = 1'h0, bandgap_ref_pin = 1'h0;
  logic [15:0] conv_code = 16'h0;
  logic convert_pin, sck, sdi, sdo_out, sdo_oe_n, converting, core_powered, ref_enable;
  logic ref_buffer_enable, bandgap_enable, chain_mode, rate_too_fast, first_result_invalid;
  int num_errors = 0, total_checks = 0, cycles = 0;
  sarcs_top dut (.clk_sys(clk_sys), .rst(rst), .convert_pin(convert_pin), .sck(sck), .sdi(sdi),
    .speed_mode_select(speed_mode_select), .ref_powerdown(ref_powerdown),
    .bandgap_ref_pin(bandgap_ref_pin), .conv_code(conv_code), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .converting(converting), .core_powered(core_powered),
    .ref_enable(ref_enable), .ref_buffer_enable(ref_buffer_enable),
    .bandgap_enable(bandgap_enable), .chain_mode(chain_mode), .rate_too_fast(rate_too_fast),
    .first_result_invalid(first_result_invalid));
  sarcs_host host (.clk_sys(clk_sys), .sdo_out(sdo_out), .convert_pin(convert_pin),
    .sck(sck), .sdi(sdi));
  always #5 clk_sys = !clk_sys;
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Ceiling well above the nine hundred or so cycles used
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic t_ref();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      {ref_powerdown, bandgap_ref_pin} = i[1:0];
      #1;
      `CHK(ref_enable, !i[1])
      `CHK({ref_buffer_enable, bandgap_enable}, {i != 2, !i[1]})
    end
  endtask
  task automatic t_cs();
    logic [31:0] w;
    speed_mode_select = 1'h1;
    conv_code = 16'hA5C3;
    host.start(1'h0, 1'h0);
    `CHK({chain_mode, first_result_invalid, core_powered}, 3'h3)
    host.read(16, 32'h0, w);
    `CHK(w[15:0], 16'hA5C3)
  endtask
  task automatic t_chain();
    logic [31:0] w;
    speed_mode_select = 1'h0;
    conv_code = 16'h3C5A;
    host.start(1'h1, 1'h0);
    `CHK({chain_mode, core_powered, rate_too_fast}, 3'h4)
    host.read(32, 32'hB00F0000, w);
    `CHK(w, 32'h3C5AB00F)
  endtask
  task automatic t_busy();
    conv_code = 16'hFFFF;
    host.start(1'h0, 1'h1);
    `CHK(sdo_out, 1'h0)
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'h0;
    t_ref();
    t_cs();
    t_chain();
    t_busy();
    final_report();
  end
endmodule
